/* File: inc/ssc_pkg.sv */
/*
  Constants, register map and types of the servo switch configuration
  decoder. Assumes a 25 MHz core clock and an 8-bit word-aligned register
  address with 32-bit data.
*/
package ssc_pkg;

  // Clock and power-up settling interval
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned STARTUP_MS      = 2000;
  localparam int unsigned STARTUP_CYCLES  = STARTUP_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W           = 26;

  // Register port
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 32;
  localparam logic [7:0]  REG_CONFIG       = 8'h00;
  localparam logic [7:0]  REG_FILTER_PARAM = 8'h04;
  localparam logic [7:0]  REG_STATUS       = 8'h08;
  localparam logic [7:0]  REG_IRQ_STATUS   = 8'h0c;
  localparam logic [7:0]  REG_IRQ_ENABLE   = 8'h10;
  localparam logic [7:0]  REG_IRQ_CLEAR    = 8'h14;

  // Communications DIP bank pin positions
  localparam int unsigned DIP_RSVD_A      = 0;
  localparam int unsigned DIP_RSVD_B      = 1;
  localparam int unsigned DIP_AXIS_RANGE  = 2;
  localparam int unsigned DIP_FILTER_SRC  = 3;

  // Axis and filter codes
  localparam logic [4:0]  AXIS_HIGH_BASE   = 5'h10;
  localparam logic [3:0]  AXIS_DISABLED_SW = 4'h0;
  localparam logic [3:0]  FILTER_PARAM_RST = 4'h0;
  localparam logic [3:0]  FILTER_MAX_VALID = 4'h7;

  // Step-command smoothing time in ms: 45 50 60 65 70 80 85 170
  localparam logic [7:0]  ACCEL_MS_TBL [0:7] = '{
    8'h2d, 8'h32, 8'h3c, 8'h41, 8'h46, 8'h50, 8'h55, 8'haa
  };

  // Interrupt status bit positions
  localparam int unsigned IRQ_W           = 4;
  localparam int unsigned IRQ_STARTUP     = 0;
  localparam int unsigned IRQ_FIL_INVALID = 1;
  localparam int unsigned IRQ_RSVD_PIN    = 2;
  localparam int unsigned IRQ_FAULT       = 3;

  // CONFIG register fields
  localparam int unsigned CFG_AXIS_LSB    = 0;
  localparam int unsigned CFG_AXIS_EN     = 5;
  localparam int unsigned CFG_FIL_LSB     = 8;
  localparam int unsigned CFG_FIL_SRC     = 12;
  localparam int unsigned CFG_RANGE       = 13;
  localparam int unsigned CFG_RSVD_ERR    = 14;

  // STATUS register fields
  localparam int unsigned ST_DONE         = 0;
  localparam int unsigned ST_ALARM        = 1;
  localparam int unsigned ST_FIL_VALID    = 2;
  localparam int unsigned ST_LED_ALM      = 3;
  localparam int unsigned ST_LED_RDY      = 4;
  localparam int unsigned ST_LED_REF      = 5;
  localparam int unsigned ST_ACCEL_LSB    = 8;

  typedef enum logic [1:0] {
    ST_LATCH,
    ST_SETTLE,
    ST_RUN
  } ssc_phase_t;

endpackage

/* File: design/ssc_filter_map.sv */
/*
  Filter code to step-command smoothing time lookup.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none

module ssc_filter_map
  import ssc_pkg::*;
(
  // Code in
  input  wire logic [3:0] code_in,
  // Mapped time
  output logic      [7:0] accel_ms_out,
  output logic            valid_out
);

  always_comb begin
    valid_out    = (code_in <= FILTER_MAX_VALID);
    accel_ms_out = 8'h00;
    if (valid_out) begin
      accel_ms_out = ACCEL_MS_TBL[code_in[2:0]];
    end
  end

endmodule

`default_nettype wire

/* File: design/ssc_startup_timer.sv */
/*
  One-shot power-up settling timer: counts a fixed number of clock cycles
  after a start pulse and then holds done high.
  Assumes start is pulsed once after reset.
*/
`timescale 1ns/1ps
`default_nettype none

module ssc_startup_timer
  import ssc_pkg::*;
#(
  parameter int unsigned CYCLES = STARTUP_CYCLES
)
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Control
  input  wire logic start_in,
  output logic      done_out
);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [TMR_W-1:0] count;
  } ssc_tmr_t;

  ssc_tmr_t q, d;

  always_comb begin
    d = q;
    if (start_in) begin
      d.busy  = 1'b1;
      d.done  = 1'b0;
      d.count = TMR_W'(CYCLES - 1);
    end else if (q.busy) begin
      if (q.count == '0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.count = q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_out = q.done;

endmodule

`default_nettype wire

/* File: design/ssc_config_decode.sv */
/*
  Power-up switch configuration decoder of a networked servo drive.
  Latches the DIP bank and rotary switches once after reset, derives the
  fieldbus axis number, selects and maps the command filter code, and
  sequences the alarm output and front indicators through the settling
  interval. Software reaches it over a plain strobe register port.
  Assumes all inputs are synchronous to CLOCK_IN and that reset is the
  power-on reset.

  // Function
  // - DIP bank sampled only at power-up
  // - Range off: rotary 1..F gives axis 1..15, 0 disables
  // - Range on: axis is 16 plus rotary value
  // - Fourth DIP pin selects filter code source
  // - Pin off: filter code from filter rotary
  // - Pin on: filter code from stored parameter
  // - Filter code 0 gives shortest smoothing
  // - Codes 0..7 map to 45..170 ms
  // - Alarm output not valid for two seconds
  // - Power-up lights alarm and ready indicators
  // - After settling, alarm off, reference lit if healthy
  // - Stored parameter shares rotary codes, default zero
*/
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ssc_config_decode
  import ssc_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = STARTUP_CYCLES
)
(
  // Clock and reset
  input  wire logic              CLOCK_IN,
  input  wire logic              RESETN_IN,
  // Front panel switches
  input  wire logic [3:0]        COMM_DIP_BANK_IN,
  input  wire logic [3:0]        AXIS_ROTARY_SWITCH_IN,
  input  wire logic [3:0]        FILTER_ROTARY_SWITCH_IN,
  // Drive fault from the motion logic
  input  wire logic              FAULT_IN,
  // Register port
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WR_DATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [DATA_W-1:0] RD_DATA_OUT,
  // Decoded configuration
  output logic      [4:0]        AXIS_NUMBER_OUT,
  output logic                   AXIS_ENABLE_OUT,
  output logic      [3:0]        FILTER_CODE_OUT,
  output logic      [7:0]        ACCEL_TIME_MS_OUT,
  output logic                   FILTER_VALID_OUT,
  output logic                   CONFIG_ERROR_OUT,
  // Alarm output and indicators
  output logic                   ALARM_VALID_OUT,
  output logic                   ALARM_OUTPUT_INDICATOR_OUT,
  output logic                   LED_ALARM_OUT,
  output logic                   LED_READY_OUT,
  output logic                   LED_REF_OUT,
  // Interrupt
  output logic                   IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    ssc_phase_t       phase;
    logic [3:0]       dip;
    logic [3:0]       fil_sw;
    logic [3:0]       fil_param;
    logic [3:0]       fil_code;
    logic [4:0]       axis_num;
    logic             axis_en;
    logic [7:0]       accel_ms;
    logic             fil_valid;
    logic             cfg_err;
    logic             alarm_valid;
    logic             alarm;
    logic             led_alm;
    logic             led_rdy;
    logic             led_ref;
    logic             fault_seen;
    logic             timer_start;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic             irq;
    logic [DATA_W-1:0] rd_data;
  } ssc_core_t;

  localparam ssc_core_t CORE_RESET = '{
    phase:     ST_LATCH,
    fil_param: FILTER_PARAM_RST,
    led_alm:   1'b1,
    led_rdy:   1'b1,
    default:   '0
  };

  ssc_core_t q, d;

  logic       timer_done;
  logic [3:0] fil_sel;
  logic [7:0] map_ms;
  logic       map_valid;
  logic       healthy_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  ssc_startup_timer #(
    .CYCLES (STARTUP_CYC)
  ) u_timer (
    .clk_in    (CLOCK_IN),
    .resetn_in (RESETN_IN),
    .start_in  (q.timer_start),
    .done_out  (timer_done)
  );

  // Source chosen by the latched fourth DIP pin
  assign fil_sel = q.dip[DIP_FILTER_SRC] ? q.fil_param
                                         : q.fil_sw;

  ssc_filter_map u_map (
    .code_in      (fil_sel),
    .accel_ms_out (map_ms),
    .valid_out    (map_valid)
  );

  assign healthy_fault = FAULT_IN | q.cfg_err | ~q.fil_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic             bad;
    ev            = '0;
    clr           = '0;
    bad           = 1'b0;
    d             = q;
    d.rd_data     = '0;
    d.timer_start = 1'b0;

    unique case (q.phase)
      ST_LATCH: begin
        // Switches are captured once; later changes are never looked at
        d.dip    = COMM_DIP_BANK_IN;
        d.fil_sw = FILTER_ROTARY_SWITCH_IN;
        if (COMM_DIP_BANK_IN[DIP_AXIS_RANGE]) begin
          d.axis_num = AXIS_HIGH_BASE | 5'(AXIS_ROTARY_SWITCH_IN);
          d.axis_en  = 1'b1;
        end else begin
          d.axis_num = {1'b0, AXIS_ROTARY_SWITCH_IN};
          d.axis_en  = AXIS_ROTARY_SWITCH_IN != AXIS_DISABLED_SW;
        end
        d.cfg_err = ~COMM_DIP_BANK_IN[DIP_RSVD_A]
                  | ~COMM_DIP_BANK_IN[DIP_RSVD_B];
        ev[IRQ_RSVD_PIN] = d.cfg_err;
        d.timer_start    = 1'b1;
        d.phase          = ST_SETTLE;
      end
      ST_SETTLE: begin
        // Alarm output held not valid, both indicators lit
        d.alarm_valid = 1'b0;
        d.led_alm     = 1'b1;
        d.led_rdy     = 1'b1;
        if (timer_done) begin
          // Filter code committed only once the settling interval ends
          d.fil_code  = fil_sel;
          d.accel_ms  = map_ms;
          d.fil_valid = map_valid;
          bad         = FAULT_IN | q.cfg_err | ~map_valid;
          d.alarm_valid = 1'b1;
          d.alarm     = bad;
          d.led_alm   = bad;
          d.led_rdy   = 1'b0;
          d.led_ref   = ~bad;
          d.fault_seen = FAULT_IN;
          ev[IRQ_STARTUP]     = 1'b1;
          ev[IRQ_FIL_INVALID] = ~map_valid;
          ev[IRQ_FAULT]       = FAULT_IN;
          d.phase     = ST_RUN;
        end
      end
      ST_RUN: begin
        // A persistent alarm indicator marks an error
        d.alarm      = healthy_fault;
        d.led_alm    = healthy_fault;
        d.led_ref    = ~healthy_fault;
        d.fault_seen = FAULT_IN;
        ev[IRQ_FAULT] = FAULT_IN & ~q.fault_seen;
      end
    endcase

    // Register writes
    if (WR_IN) begin
      unique case (ADDR_IN)
        REG_FILTER_PARAM: d.fil_param = WR_DATA_IN[3:0];
        REG_IRQ_ENABLE:   d.irq_en    = WR_DATA_IN[IRQ_W-1:0];
        REG_IRQ_CLEAR:    clr         = WR_DATA_IN[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // New events win over a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq      = |(d.irq_stat & d.irq_en);

    // Register reads, data stand the following cycle only
    if (RD_IN) begin
      unique case (ADDR_IN)
        REG_CONFIG: begin
          d.rd_data[CFG_AXIS_LSB +: 5] = q.axis_num;
          d.rd_data[CFG_AXIS_EN]       = q.axis_en;
          d.rd_data[CFG_FIL_LSB +: 4]  = q.fil_code;
          d.rd_data[CFG_FIL_SRC]       = q.dip[DIP_FILTER_SRC];
          d.rd_data[CFG_RANGE]         = q.dip[DIP_AXIS_RANGE];
          d.rd_data[CFG_RSVD_ERR]      = q.cfg_err;
        end
        REG_FILTER_PARAM: d.rd_data[3:0] = q.fil_param;
        REG_STATUS: begin
          d.rd_data[ST_DONE]           = (q.phase == ST_RUN);
          d.rd_data[ST_ALARM]          = q.alarm;
          d.rd_data[ST_FIL_VALID]      = q.fil_valid;
          d.rd_data[ST_LED_ALM]        = q.led_alm;
          d.rd_data[ST_LED_RDY]        = q.led_rdy;
          d.rd_data[ST_LED_REF]        = q.led_ref;
          d.rd_data[ST_ACCEL_LSB +: 8] = q.accel_ms;
        end
        REG_IRQ_STATUS: d.rd_data[IRQ_W-1:0] = q.irq_stat;
        REG_IRQ_ENABLE: d.rd_data[IRQ_W-1:0] = q.irq_en;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RD_DATA_OUT                = q.rd_data;
  assign AXIS_NUMBER_OUT            = q.axis_num;
  assign AXIS_ENABLE_OUT            = q.axis_en;
  assign FILTER_CODE_OUT            = q.fil_code;
  assign ACCEL_TIME_MS_OUT          = q.accel_ms;
  assign FILTER_VALID_OUT           = q.fil_valid;
  assign CONFIG_ERROR_OUT           = q.cfg_err;
  assign ALARM_VALID_OUT            = q.alarm_valid;
  assign ALARM_OUTPUT_INDICATOR_OUT = q.alarm;
  assign LED_ALARM_OUT              = q.led_alm;
  assign LED_READY_OUT              = q.led_rdy;
  assign LED_REF_OUT                = q.led_ref;
  assign IRQ_OUT                    = q.irq;

endmodule

`default_nettype wire

/* File: sim/ssc_host_model.sv */
/*
  Host controller model: watches the drive alarm line.
  Assumes the drive's clock and power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Drive alarm
  input  wire logic alarm_valid_in,
  input  wire logic alarm_in,
  output logic      alarm_seen_out
);
  // Alarm is evaluated only once the drive reports it valid
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alarm_seen_out <= 1'b0;
    end else if (alarm_valid_in && alarm_in) begin
      alarm_seen_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/ssc_monitor.sv */
/*
  Port checker of the switch configuration decoder.
  Assumes it is bound to the decoder and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_monitor
  import ssc_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = 20
)
(
  // Clock, reset, fault
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        FAULT_IN,
  // Decoded outputs
  input  wire logic [4:0]  AXIS_NUMBER_OUT,
  input  wire logic        AXIS_ENABLE_OUT,
  input  wire logic [3:0]  FILTER_CODE_OUT,
  input  wire logic [7:0]  ACCEL_TIME_MS_OUT,
  input  wire logic        FILTER_VALID_OUT,
  input  wire logic        CONFIG_ERROR_OUT,
  input  wire logic        ALARM_VALID_OUT,
  input  wire logic        ALARM_OUTPUT_INDICATOR_OUT,
  input  wire logic        LED_ALARM_OUT,
  input  wire logic        LED_READY_OUT,
  input  wire logic        LED_REF_OUT
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  // Edges since reset release, saturating; wide enough for the full interval
  always_comb cnt_d = (cnt_q == 32'hffffffff) ? cnt_q : cnt_q + 32'h1;
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_run_fault;
    ALARM_VALID_OUT && FAULT_IN;
  endsequence
  sequence s_alarm_lit;
    ALARM_OUTPUT_INDICATOR_OUT && LED_ALARM_OUT && !LED_REF_OUT;
  endsequence

  property p_axis_off;
    !AXIS_ENABLE_OUT |-> AXIS_NUMBER_OUT == 5'h00;
  endproperty
  property p_axis_hold;
    ALARM_VALID_OUT |-> $stable(AXIS_NUMBER_OUT) && $stable(AXIS_ENABLE_OUT);
  endproperty
  property p_accel;
    ALARM_VALID_OUT |-> ACCEL_TIME_MS_OUT ==
      (FILTER_VALID_OUT ? ACCEL_MS_TBL[FILTER_CODE_OUT[2:0]] : 8'h00);
  endproperty
  property p_fil_valid;
    ALARM_VALID_OUT |-> FILTER_VALID_OUT == (FILTER_CODE_OUT <= 4'h7);
  endproperty
  property p_settle;
    ALARM_VALID_OUT == (32'(cnt_q) >= STARTUP_CYC + 3);
  endproperty
  property p_power_led;
    !ALARM_VALID_OUT |-> LED_ALARM_OUT && LED_READY_OUT && !LED_REF_OUT;
  endproperty
  property p_run_led;
    ALARM_VALID_OUT |-> !LED_READY_OUT && (LED_REF_OUT == !LED_ALARM_OUT);
  endproperty
  property p_fault_alarm;
    s_run_fault |=> s_alarm_lit;
  endproperty
  property p_cfg_err;
    CONFIG_ERROR_OUT && ALARM_VALID_OUT |-> s_alarm_lit;
  endproperty

  a_axis_off: assert property (p_axis_off)
    else $error("Disabled axis with nonzero number");
  a_axis_hold: assert property (p_axis_hold)
    else $error("Axis outputs changed after power-up");
  a_accel: assert property (p_accel)
    else $error("Smoothing time does not match filter code");
  a_fil_valid: assert property (p_fil_valid)
    else $error("Filter valid flag wrong for code");
  a_settle: assert property (p_settle)
    else $error("Alarm valid at wrong cycle");
  a_power_led: assert property (p_power_led)
    else $error("Power-up indicators wrong");
  a_run_led: assert property (p_run_led)
    else $error("Run indicators wrong");
  a_fault_alarm: assert property (p_fault_alarm)
    else $error("Fault not shown on alarm");
  a_cfg_err: assert property (p_cfg_err)
    else $error("Reserved pin error not raised as alarm");
endmodule
bind ssc_config_decode ssc_monitor #(.STARTUP_CYC(STARTUP_CYC)) i_mon (.*);
`default_nettype wire

/* File: sim/tb_servo_switch_config_decode.sv */
/*
  Self-checking bench of the switch configuration decoder.
  Assumes a short settling parameter and the host model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_servo_switch_config_decode;
  import ssc_pkg::*;
  localparam int unsigned SC = 20;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        flt = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  dip = 4'h3;
  logic [3:0]  ax = 4'h0;
  logic [3:0]  fl = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdo;
  logic [31:0] rv;
  logic [4:0]  axn;
  logic [3:0]  fc;
  logic [7:0]  acc;
  logic        axe, fv, cerr, av, alarm_output_indicator, l_alm, l_rdy, l_ref, irq, seen;
  int          fails = 0;
  int          checked = 0;
  logic [7:0]  acc_tbl [0:7] = '{8'h2d, 8'h32, 8'h3c, 8'h41,
                                 8'h46, 8'h50, 8'h55, 8'haa};

  always #20 clk = ~clk;

  ssc_config_decode #(.STARTUP_CYC(SC)) i_dut (
    .CLOCK_IN(clk), .RESETN_IN(rstn), .COMM_DIP_BANK_IN(dip),
    .AXIS_ROTARY_SWITCH_IN(ax), .FILTER_ROTARY_SWITCH_IN(fl),
    .FAULT_IN(flt), .ADDR_IN(adr), .WR_DATA_IN(wd), .WR_IN(wr),
    .RD_IN(rd), .RD_DATA_OUT(rdo), .AXIS_NUMBER_OUT(axn),
    .AXIS_ENABLE_OUT(axe), .FILTER_CODE_OUT(fc), .ACCEL_TIME_MS_OUT(acc),
    .FILTER_VALID_OUT(fv), .CONFIG_ERROR_OUT(cerr), .ALARM_VALID_OUT(av),
    .ALARM_OUTPUT_INDICATOR_OUT(alarm_output_indicator), .LED_ALARM_OUT(l_alm),
    .LED_READY_OUT(l_rdy), .LED_REF_OUT(l_ref), .IRQ_OUT(irq));

  ssc_host_model i_host (
    .clk_in(clk), .resetn_in(rstn), .alarm_valid_in(av),
    .alarm_in(alarm_output_indicator), .alarm_seen_out(seen));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic pwr(input logic [3:0] d, input logic [3:0] a,
                     input logic [3:0] f);
    @(posedge clk);
    dip <= d; ax <= a; fl <= f; flt <= 1'b0; rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task automatic wait_run;
    int i;
    for (i = 0; i < SC + 8 && av !== 1'b1; i++) begin
      @(posedge clk); #1;
    end
    if (av !== 1'b1) begin
      chk(av, 1'b1);
      end_sim();
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    adr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdo;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_power;
    pwr(4'h3, 4'h1, 4'h0);
    repeat (SC + 2) @(posedge clk);
    #1 chk({av, l_alm, l_rdy, l_ref}, 4'b0110);
    @(posedge clk);
    #1 chk({av, l_alm, l_rdy, l_ref}, 4'b1001);
    chk(irq, 1'b0);
    rreg(REG_IRQ_STATUS, rv);
    chk(rv, 32'h1);
    rreg(REG_FILTER_PARAM, rv);
    chk(rv, 32'h0);
    wreg(REG_IRQ_ENABLE, 32'h1);
    @(posedge clk);
    #1 chk(irq, 1'b1);
    wreg(REG_IRQ_CLEAR, 32'h1);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    rreg(8'h20, rv);
    chk(rv, 32'h0);
    chk(seen, 1'b0);
    @(posedge clk);
    flt <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({alarm_output_indicator, l_alm, l_ref}, 3'b110);
    chk(seen, 1'b1);
    rreg(REG_IRQ_STATUS, rv);
    chk(rv, 32'h8);
    chk(irq, 1'b0);
    $display("t_power done");
  endtask

  task automatic t_axis;
    logic [3:0] td [0:4] = '{4'h3, 4'h3, 4'h3, 4'h7, 4'h7};
    logic [3:0] ta [0:4] = '{4'h0, 4'h1, 4'hf, 4'h0, 4'hf};
    logic [5:0] te [0:4] = '{6'h00, 6'h21, 6'h2f, 6'h30, 6'h3f};
    for (int i = 0; i < 5; i++) begin
      pwr(td[i], ta[i], 4'h0);
      repeat (3) @(posedge clk);
      #1 chk({axe, axn}, te[i]);
    end
    @(posedge clk);
    dip <= 4'h3; ax <= 4'h2;
    wait_run();
    chk({axe, axn}, 6'h3f);
    $display("t_axis done");
  endtask

  task automatic t_filter;
    for (int c = 0; c < 10; c++) begin
      pwr(4'h3, 4'h1, c[3:0]);
      wait_run();
      chk(fc, c[3:0]);
      chk(acc, (c < 8) ? acc_tbl[c] : 8'h00);
      chk({fv, alarm_output_indicator}, (c < 8) ? 2'b10 : 2'b01);
      rreg(REG_IRQ_STATUS, rv);
      chk(rv, (c < 8) ? 32'h1 : 32'h3);
    end
    $display("t_filter done");
  endtask

  task automatic t_param;
    pwr(4'hb, 4'h1, 4'h7);
    wreg(REG_FILTER_PARAM, 32'h5);
    wait_run();
    chk(fc, 4'h5);
    chk(acc, 8'h50);
    rreg(REG_CONFIG, rv);
    chk(rv, 32'h1521);
    rreg(REG_STATUS, rv);
    chk(rv, 32'h5025);
    @(posedge clk);
    #1 chk(rdo, 32'h0);
    pwr(4'h0, 4'h1, 4'h0);
    wait_run();
    chk({cerr, alarm_output_indicator, l_ref}, 3'b110);
    rreg(REG_IRQ_STATUS, rv);
    chk(rv, 32'h5);
    $display("t_param done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_power();
    t_axis();
    t_filter();
    t_param();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    chk(32'h0, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
